// ---- design/tap_map.svh ----
// codes, field widths and counts of the test access port
`ifndef TAP_MAP_SVH
`define TAP_MAP_SVH
// ----------------------------------------------------------------
// register widths
// ----------------------------------------------------------------
`define TAP_IR_WIDTH 3
`define TAP_ID_WIDTH 32
`define TAP_ID_VER_WIDTH 4
`define TAP_ID_PART_WIDTH 16
`define TAP_ID_MFR_WIDTH 11
`define TAP_ID_LSB 1'h1
// ----------------------------------------------------------------
// instruction codes
// ----------------------------------------------------------------
`define TAP_OP_EXTEST 3'h0
`define TAP_OP_IDCODE 3'h1
`define TAP_OP_SAMPLE 3'h2
`define TAP_OP_CLAMP 3'h3
`define TAP_OP_HIGHZ 3'h4
`define TAP_OP_BYPASS 3'h7
// fixed pattern loaded into the instruction shift stage on capture
`define TAP_IR_CAPTURE 3'h1
// ----------------------------------------------------------------
// counts
// ----------------------------------------------------------------
`define TAP_TLR_HIGHS 3'h5
`endif

// ---- design/tap_pkg.sv ----
// types and shared decode of the test access port
package tap_pkg;
`include "tap_map.svh"
  // controller states
  typedef enum logic [3:0] {
    test_logic_reset, run_test_idle, select_dr, capture_dr,
    shift_dr, exit1_dr, pause_dr, exit2_dr, update_dr,
    select_ir, capture_ir, shift_ir, exit1_ir, pause_ir,
    exit2_ir, update_ir
  } tap_state_t;
  // instruction word
  typedef logic [`TAP_IR_WIDTH-1:0] instr_t;
  // data register in the scan path
  typedef enum logic [1:0] {dr_bypass, dr_bsr, dr_ident} dr_sel_t;
  // decode the current instruction into the selected data register
  function automatic dr_sel_t dr_select(instr_t op);
    if (op == `TAP_OP_EXTEST || op == `TAP_OP_SAMPLE) begin
      return dr_bsr;
    end else if (op == `TAP_OP_IDCODE) begin
      return dr_ident;
    end else begin
      return dr_bypass; // bypass, clamp, highz and unknown codes
    end
  endfunction : dr_select
endpackage : tap_pkg

// ---- design/scan_shift_reg.sv ----
// shift stage with latched parallel output for one scan register
`timescale 1ns/1ps
module scan_shift_reg #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] PAR_RESET = '0
) (
  input wire logic clock, // system clock
  input wire logic rst, // synchronous reset
  input wire logic capture, // parallel load of the shift stage
  input wire logic shift, // one step toward serial output
  input wire logic update, // copy shift stage to parallel output
  input wire logic preset, // force parallel output to preset value
  input wire logic [WIDTH-1:0] capture_value, // value taken on capture
  input wire logic [WIDTH-1:0] preset_value, // value forced by preset
  input wire logic serial_in, // serial data into the top stage
  output logic [WIDTH-1:0] shift_q, // shift stage, bit 0 leaves first
  output logic [WIDTH-1:0] par_q // latched parallel output
);
  if (WIDTH < 1) begin : g_width_check
    $error("scan_shift_reg: WIDTH must be at least 1");
  end
  logic [WIDTH-1:0] shifted; // shift stage moved one step
  // ----------------------------------------------------------------
  // shift stage
  // ----------------------------------------------------------------
  // new bit enters at the top, bit 0 drops out to the serial output
  always_comb begin
    shifted = shift_q >> 1;
    shifted[WIDTH-1] = serial_in;
  end
  // capture has priority; outside capture and shift the stage holds
  always_ff @(posedge clock) begin
    if (rst) begin
      shift_q <= '0;
    end else if (capture) begin
      shift_q <= capture_value;
    end else if (shift) begin
      shift_q <= shifted;
    end
  end
  // ----------------------------------------------------------------
  // parallel output latch
  // ----------------------------------------------------------------
  // only update or preset moves it, so shifting never shows on the outputs
  always_ff @(posedge clock) begin
    if (rst) begin
      par_q <= PAR_RESET;
    end else if (preset) begin
      par_q <= preset_value;
    end else if (update) begin
      par_q <= shift_q;
    end
  end
endmodule : scan_shift_reg

// ---- design/tap_fsm.sv ----
// sixteen-state test access port controller
`timescale 1ns/1ps
module tap_fsm (
  input wire logic clock, // system clock
  input wire logic rst, // synchronous reset
  input wire logic tck_rise, // one-cycle pulse per test clock rising edge
  input wire logic tms, // synchronised mode select
  input wire logic trst, // synchronised test reset, active high
  output tap_pkg::tap_state_t state_reg // current controller state
);
  // next state from the current state and mode select
  function automatic tap_pkg::tap_state_t next_state(
    tap_pkg::tap_state_t s, logic m);
    case (s)
      tap_pkg::test_logic_reset: return m ? tap_pkg::test_logic_reset : tap_pkg::run_test_idle;
      tap_pkg::run_test_idle: return m ? tap_pkg::select_dr : tap_pkg::run_test_idle;
      tap_pkg::select_dr: return m ? tap_pkg::select_ir : tap_pkg::capture_dr;
      tap_pkg::capture_dr: return m ? tap_pkg::exit1_dr : tap_pkg::shift_dr;
      tap_pkg::shift_dr: return m ? tap_pkg::exit1_dr : tap_pkg::shift_dr;
      tap_pkg::exit1_dr: return m ? tap_pkg::update_dr : tap_pkg::pause_dr;
      tap_pkg::pause_dr: return m ? tap_pkg::exit2_dr : tap_pkg::pause_dr;
      tap_pkg::exit2_dr: return m ? tap_pkg::update_dr : tap_pkg::shift_dr;
      tap_pkg::update_dr: return m ? tap_pkg::select_dr : tap_pkg::run_test_idle;
      tap_pkg::select_ir: return m ? tap_pkg::test_logic_reset : tap_pkg::capture_ir;
      tap_pkg::capture_ir: return m ? tap_pkg::exit1_ir : tap_pkg::shift_ir;
      tap_pkg::shift_ir: return m ? tap_pkg::exit1_ir : tap_pkg::shift_ir;
      tap_pkg::exit1_ir: return m ? tap_pkg::update_ir : tap_pkg::pause_ir;
      tap_pkg::pause_ir: return m ? tap_pkg::exit2_ir : tap_pkg::pause_ir;
      tap_pkg::exit2_ir: return m ? tap_pkg::update_ir : tap_pkg::shift_ir;
      default: return m ? tap_pkg::select_dr : tap_pkg::run_test_idle;
    endcase
  endfunction : next_state
  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // moves only on test clock rising edges; test reset forces reset state
  always_ff @(posedge clock) begin
    if (rst || trst) begin
      state_reg <= tap_pkg::test_logic_reset; // [R25]
    end else if (tck_rise) begin
      state_reg <= next_state(state_reg, tms); // [R1] [R3] [R6] [R7] [R8] [R10] [R14] [R24]
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_step(tap_pkg::tap_state_t st, logic m);
    tck_rise && !trst && state_reg == st && tms == m;
  endsequence
  property p_r1;
    @(posedge clock) disable iff (rst) !tck_rise && !trst |=> $stable(state_reg);
  endproperty
  a_r1: assert property (p_r1) else $error("state moved without a rising edge"); // [R1]
  property p_r3;
    @(posedge clock) disable iff (rst)
      s_step(tap_pkg::select_dr, 1'b0) |=> state_reg == tap_pkg::capture_dr;
  endproperty
  a_r3: assert property (p_r3) else $error("select dr did not go to capture"); // [R3]
  property p_r6;
    @(posedge clock) disable iff (rst)
      s_step(tap_pkg::exit1_dr, 1'b1) |=> state_reg == tap_pkg::update_dr;
  endproperty
  a_r6: assert property (p_r6) else $error("exit1 dr did not go to update"); // [R6]
  property p_r8;
    @(posedge clock) disable iff (rst)
      s_step(tap_pkg::exit2_dr, 1'b0) |=> state_reg == tap_pkg::shift_dr;
  endproperty
  a_r8: assert property (p_r8) else $error("exit2 dr did not return to shift"); // [R8]
  property p_r24;
    @(posedge clock) disable iff (rst)
      s_step(tap_pkg::exit2_ir, 1'b0) |=> state_reg == tap_pkg::shift_ir;
  endproperty
  a_r24: assert property (p_r24) else $error("exit2 ir did not return to shift"); // [R24]
  property p_r10;
    @(posedge clock) disable iff (rst)
      s_step(tap_pkg::select_ir, 1'b1) |=> state_reg == tap_pkg::test_logic_reset;
  endproperty
  a_r10: assert property (p_r10) else $error("select ir did not go to reset"); // [R10]
  property p_r7;
    @(posedge clock) disable iff (rst)
      s_step(tap_pkg::pause_dr, 1'b0) |=> state_reg == tap_pkg::pause_dr;
  endproperty
  a_r7: assert property (p_r7) else $error("pause dr did not hold"); // [R7]
  property p_r14;
    @(posedge clock) disable iff (rst)
      s_step(tap_pkg::pause_ir, 1'b0) |=> state_reg == tap_pkg::pause_ir;
  endproperty
  a_r14: assert property (p_r14) else $error("pause ir did not hold"); // [R14]
endmodule : tap_fsm

// ---- design/boundary_scan_tap.sv ----
// boundary-scan test access port with instruction, bypass, id and boundary registers
// What this block does
// [R1] state moves on test clock rising edges
// [R2] power-up: reset state, identify instruction current
// [R3] select-dr holds registers, branches on mode
// [R4] capture-dr loads selected register if allowed
// [R5] shift-dr moves selected register toward output
// [R6] exit1-dr: high to update, low pause
// [R7] pause-dr holds contents, waits for mode high
// [R8] exit2-dr: high to update, low shift
// [R9] update-dr falling edge latches parallel outputs
// [R10] select-ir: low capture, high reset state
// [R11] capture-ir loads fixed value into instruction
// [R12] shift-ir shifts instruction, parallel registers hold
// [R13] update-ir falling edge latches instruction
// [R14] pause-ir holds instruction shifting, waits high
// [R15] latched instruction current; then idle or select
// [R16] instruction register: three-bit shift and latch
// [R17] code 010 samples pins into boundary
// [R18] code 111 routes data through bypass
// [R19] code 000 drives pins from boundary
// [R20] code 011 clamps pins, bypass in path
// [R21] code 100 floats pins, bypass in path
// [R22] identify instruction captures and shifts id
// [R23] id register 32 bits, selected in reset
// [R24] exit2-ir with mode low returns shift
// [R25] test reset or five highs reach reset
// [R26] data out on falling edges, shift only
`timescale 1ns/1ps
`include "tap_map.svh"
module boundary_scan_tap #(
  parameter int N_IN = 8, // digital input pins in the boundary
  parameter int N_OUT = 8, // digital output pins in the boundary
  parameter logic [`TAP_ID_VER_WIDTH-1:0] ID_VERSION = 4'h0, // arbitrary value
  parameter logic [`TAP_ID_PART_WIDTH-1:0] ID_PART = 16'h0A5C, // arbitrary value
  parameter logic [`TAP_ID_MFR_WIDTH-1:0] ID_MAKER = 11'h0AA // arbitrary value
) (
  input wire logic clock, // system clock, 200 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic test_reset_n, // test reset pin, active low
  input wire logic test_clock, // test clock pin
  input wire logic test_mode_select, // mode select pin
  input wire logic test_data_in, // serial data pin in
  output logic test_data_out, // serial data pin out
  output logic test_data_out_oe, // high while data out is driven
  input wire logic [N_IN-1:0] pin_in, // digital input pins
  output logic [N_IN-1:0] core_in, // input pins as seen by system logic
  input wire logic [N_OUT-1:0] core_out, // output values from system logic
  input wire logic [N_OUT-1:0] core_oe, // output enables from system logic
  output logic [N_OUT-1:0] pin_out, // digital output pins
  output logic [N_OUT-1:0] pin_oe // output pin enables
);
  localparam int BSR_W = N_IN + N_OUT; // boundary cells, inputs low
  if (N_IN < 1 || N_OUT < 1) begin : g_size_check
    $error("boundary_scan_tap: N_IN and N_OUT must be at least 1");
  end
  // identification code, bit 0 always one
  localparam logic [`TAP_ID_WIDTH-1:0] ID_CODE = {ID_VERSION, ID_PART, ID_MAKER, `TAP_ID_LSB};
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic tck_meta, tck_sync, tck_last; // test clock stages
  logic tms_meta, tms_sync; // mode select stages
  logic tdi_meta, tdi_sync; // data in stages
  logic trst_meta, trst_sync; // test reset stages, active high
  logic [N_IN-1:0] pin_meta, pin_sync; // input pin stages
  logic tck_rise; // test clock rose
  logic tck_fall; // test clock fell
  // two stages per pin; all pins share the same delay so that
  // mode select and data in line up with the clock edge
  always_ff @(posedge clock) begin
    if (rst) begin
      tck_meta <= 1'b0;
      tck_sync <= 1'b0;
      tck_last <= 1'b0;
      tms_meta <= 1'b1;
      tms_sync <= 1'b1;
      tdi_meta <= 1'b1;
      tdi_sync <= 1'b1;
      trst_meta <= 1'b1;
      trst_sync <= 1'b1;
    end else begin
      tck_meta <= test_clock;
      tck_sync <= tck_meta;
      tck_last <= tck_sync;
      tms_meta <= test_mode_select;
      tms_sync <= tms_meta;
      tdi_meta <= test_data_in;
      tdi_sync <= tdi_meta;
      trst_meta <= ~test_reset_n;
      trst_sync <= trst_meta;
    end
  end
  // input pins pass two stages before the boundary or the core sees them
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end
  // edges of the test clock, read from settled stages only
  assign tck_rise = tck_sync & ~tck_last;
  assign tck_fall = ~tck_sync & tck_last;
  // ----------------------------------------------------------------
  // controller
  // ----------------------------------------------------------------
  tap_pkg::tap_state_t state; // controller state
  tap_fsm u_fsm (
    .clock(clock),
    .rst(rst),
    .tck_rise(tck_rise),
    .tms(tms_sync),
    .trst(trst_sync),
    .state_reg(state)
  );
  // ----------------------------------------------------------------
  // instruction register
  // ----------------------------------------------------------------
  tap_pkg::instr_t ir_shift; // instruction shift stage
  tap_pkg::instr_t ir_cur; // current instruction
  tap_pkg::dr_sel_t dr_sel; // data register in the path
  logic in_tlr; // controller in reset state
  assign in_tlr = (state == tap_pkg::test_logic_reset);
  assign dr_sel = tap_pkg::dr_select(ir_cur); // [R17] [R18] [R19] [R20] [R21] [R22] [R23]
  // three-bit shift and latch; reset state forces the identify code
  scan_shift_reg #(
    .WIDTH(`TAP_IR_WIDTH),
    .PAR_RESET(`TAP_OP_IDCODE)
  ) u_ir ( // [R16]
    .clock(clock),
    .rst(rst),
    .capture(tck_rise && state == tap_pkg::capture_ir), // [R11]
    .shift(tck_rise && state == tap_pkg::shift_ir), // [R12] [R14]
    .update(tck_fall && state == tap_pkg::update_ir), // [R13] [R15]
    .preset(in_tlr), // [R2] [R22]
    .capture_value(`TAP_IR_CAPTURE),
    .preset_value(`TAP_OP_IDCODE),
    .serial_in(tdi_sync),
    .shift_q(ir_shift),
    .par_q(ir_cur)
  );
  // ----------------------------------------------------------------
  // data registers
  // ----------------------------------------------------------------
  logic dr_capture; // capture step of the data scan
  logic dr_shift; // shift step of the data scan
  logic dr_update; // update step of the data scan
  logic bypass_reg; // single bypass stage
  logic [`TAP_ID_WIDTH-1:0] id_shift; // id shift stage
  logic [BSR_W-1:0] bsr_shift; // boundary shift stage
  logic [BSR_W-1:0] bsr_par; // boundary parallel output
  assign dr_capture = tck_rise && state == tap_pkg::capture_dr; // [R4]
  assign dr_shift = tck_rise && state == tap_pkg::shift_dr; // [R5] [R7]
  assign dr_update = tck_fall && state == tap_pkg::update_dr; // [R9]
  // bypass loads zero on capture and passes data in when shifting
  always_ff @(posedge clock) begin
    if (rst) begin
      bypass_reg <= 1'b0;
    end else if (dr_sel == tap_pkg::dr_bypass && dr_capture) begin
      bypass_reg <= 1'b0;
    end else if (dr_sel == tap_pkg::dr_bypass && dr_shift) begin
      bypass_reg <= tdi_sync; // [R18] [R20] [R21]
    end
  end
  // identification register, selected in reset state and by identify
  scan_shift_reg #(
    .WIDTH(`TAP_ID_WIDTH),
    .PAR_RESET('0)
  ) u_id ( // [R23]
    .clock(clock),
    .rst(rst),
    .capture(dr_sel == tap_pkg::dr_ident && dr_capture), // [R22]
    .shift(dr_sel == tap_pkg::dr_ident && dr_shift),
    .update(dr_sel == tap_pkg::dr_ident && dr_update),
    .preset(1'b0),
    .capture_value(ID_CODE),
    .preset_value('0),
    .serial_in(tdi_sync),
    .shift_q(id_shift),
    .par_q()
  );
  // boundary register: inputs sampled from pins, outputs from drivers
  scan_shift_reg #(
    .WIDTH(BSR_W),
    .PAR_RESET('0)
  ) u_bsr (
    .clock(clock),
    .rst(rst),
    .capture(dr_sel == tap_pkg::dr_bsr && dr_capture), // [R17] [R19]
    .shift(dr_sel == tap_pkg::dr_bsr && dr_shift), // [R17]
    .update(dr_sel == tap_pkg::dr_bsr && dr_update), // [R9]
    .preset(1'b0),
    .capture_value({pin_out, pin_sync}),
    .preset_value('0),
    .serial_in(tdi_sync),
    .shift_q(bsr_shift),
    .par_q(bsr_par)
  );
  // ----------------------------------------------------------------
  // serial output
  // ----------------------------------------------------------------
  logic in_shift; // controller in either shift state
  logic dr_serial; // serial output of the selected data register
  assign in_shift = (state == tap_pkg::shift_dr) || (state == tap_pkg::shift_ir);
  // pick the serial bit of the register in the path
  always_comb begin
    if (dr_sel == tap_pkg::dr_bsr) begin
      dr_serial = bsr_shift[0];
    end else if (dr_sel == tap_pkg::dr_ident) begin
      dr_serial = id_shift[0];
    end else begin
      dr_serial = bypass_reg;
    end
  end
  // data out changes on falling edges and is driven only while shifting
  always_ff @(posedge clock) begin
    if (rst) begin
      test_data_out <= 1'b1;
      test_data_out_oe <= 1'b0;
    end else if (tck_fall) begin
      test_data_out <= (state == tap_pkg::shift_ir) ? ir_shift[0] : dr_serial; // [R26]
      test_data_out_oe <= in_shift; // [R26]
    end
  end
  // ----------------------------------------------------------------
  // pin control
  // ----------------------------------------------------------------
  logic bs_drive; // boundary drives the output pins
  assign bs_drive = (ir_cur == `TAP_OP_EXTEST) || (ir_cur == `TAP_OP_CLAMP);
  // system logic keeps running; pins follow it unless a test takes over
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_out <= '0;
      pin_oe <= '0;
      core_in <= '0;
    end else begin
      core_in <= pin_sync; // [R2]
      if (ir_cur == `TAP_OP_HIGHZ) begin
        pin_out <= core_out;
        pin_oe <= '0; // [R21]
      end else if (bs_drive) begin
        pin_out <= bsr_par[BSR_W-1:N_IN]; // [R19] [R20]
        pin_oe <= '1;
      end else begin
        pin_out <= core_out; // [R17] [R18]
        pin_oe <= core_oe;
      end
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic [2:0] high_cnt_reg; // consecutive mode-high rising edges
  always_ff @(posedge clock) begin
    if (rst) begin
      high_cnt_reg <= 3'h0;
    end else if (tck_rise && !tms_sync) begin
      high_cnt_reg <= 3'h0;
    end else if (tck_rise && high_cnt_reg != `TAP_TLR_HIGHS) begin
      high_cnt_reg <= high_cnt_reg + 3'h1;
    end
  end
  sequence s_ir_update;
    tck_fall && state == tap_pkg::update_ir;
  endsequence
  property p_r25;
    high_cnt_reg == `TAP_TLR_HIGHS |-> in_tlr;
  endproperty
  a_r25: assert property (p_r25) else $error("five highs did not reach reset"); // [R25]
  property p_r2;
    in_tlr |=> ir_cur == `TAP_OP_IDCODE;
  endproperty
  a_r2: assert property (p_r2) else $error("reset state lost identify code"); // [R2]
  property p_r13;
    s_ir_update |=> ir_cur == $past(ir_shift);
  endproperty
  a_r13: assert property (p_r13) else $error("instruction not latched on update"); // [R13]
  property p_r11;
    tck_rise && state == tap_pkg::capture_ir |=> ir_shift == `TAP_IR_CAPTURE;
  endproperty
  a_r11: assert property (p_r11) else $error("capture ir value wrong"); // [R11]
  property p_r22;
    dr_capture && dr_sel == tap_pkg::dr_ident |=> id_shift == ID_CODE;
  endproperty
  a_r22: assert property (p_r22) else $error("id not captured"); // [R22]
  property p_r5;
    dr_shift && dr_sel == tap_pkg::dr_ident |=> id_shift[`TAP_ID_WIDTH-1] == $past(tdi_sync);
  endproperty
  a_r5: assert property (p_r5) else $error("id register did not shift"); // [R5]
  property p_r18;
    dr_shift && dr_sel == tap_pkg::dr_bypass |=> bypass_reg == $past(tdi_sync);
  endproperty
  a_r18: assert property (p_r18) else $error("bypass stage did not shift"); // [R18]
  property p_r26;
    tck_fall |=> test_data_out_oe == $past(in_shift);
  endproperty
  a_r26: assert property (p_r26) else $error("data out enable wrong"); // [R26]
  property p_r9;
    !(dr_update && dr_sel == tap_pkg::dr_bsr) |=> $stable(bsr_par);
  endproperty
  a_r9: assert property (p_r9) else $error("boundary outputs moved outside update"); // [R9]
  property p_r19;
    ir_cur == `TAP_OP_EXTEST |=> pin_out == $past(bsr_par[BSR_W-1:N_IN]) && pin_oe == '1;
  endproperty
  a_r19: assert property (p_r19) else $error("extest pins not from boundary"); // [R19]
  property p_r21;
    ir_cur == `TAP_OP_HIGHZ |=> pin_oe == '0;
  endproperty
  a_r21: assert property (p_r21) else $error("highz did not float pins"); // [R21]
endmodule : boundary_scan_tap

// ---- verif/scan_ctl.sv ----
// model of the outside scan controller driving the test access pins
`timescale 1ns/1ps
module scan_ctl (
  output logic test_clock, // link clock, stands low outside frames
  output logic test_mode_select, // mode select
  output logic test_data_in, // serial data toward the device
  output logic test_reset_n, // test reset, active low
  input wire logic tdo_line // resolved serial data from the device
);
  initial begin
    test_clock = 1'b0;
    test_mode_select = 1'b1;
    test_data_in = 1'b0;
    test_reset_n = 1'b1;
  end
  // one 48 ns period: mode and data settle well before the rise
  task automatic step(input logic m, input logic d, output logic q);
    test_mode_select = m;
    test_data_in = d;
    #24;
    q = tdo_line;
    test_clock = 1'b1;
    #24;
    test_clock = 1'b0;
  endtask : step
  // idle to shift, n bits lsb first, pause after bit p if p >= 0, update, idle
  task automatic scan(input logic ir, input logic [31:0] din, input int n,
                      output logic [31:0] dout, input int p);
    logic q;
    dout = '0;
    step(1'b1, 1'b0, q);
    if (ir) begin
      step(1'b1, 1'b0, q);
    end
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1 || i == p, din[i], dout[i]);
      if (i == p) begin
        step(1'b0, 1'b0, q);
        step(1'b0, 1'b0, q);
        step(1'b1, 1'b0, q);
        if (i != n - 1) begin
          step(1'b0, 1'b0, q);
        end
      end
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask : scan
  // reach the reset state by pin or by five highs, then go idle
  task automatic to_reset(input logic hard);
    logic q;
    if (hard) begin
      test_reset_n = 1'b0;
      #50;
      test_reset_n = 1'b1;
      #50;
    end else begin
      repeat (5) step(1'b1, 1'b0, q);
    end
    step(1'b0, 1'b0, q);
  endtask : to_reset
endmodule : scan_ctl

// ---- verif/tb.sv ----
// self-checking bench of the boundary scan port
`timescale 1ns/1ps
`define CHK(w, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s expected %h seen %h", w, e, g); end end
module tb;
  logic clock; // system clock
  logic rst; // synchronous reset
  logic tclk, tms, tdi, trst_n; // link pins from the controller
  logic tdo, tdo_oe; // serial out and its enable
  wire tdo_line = tdo_oe ? tdo : 1'b1; // pull-up when released
  logic [7:0] pin_in, core_in, core_out, core_oe, pin_out, pin_oe; // pins
  logic [31:0] d; // scanned-out data
  int errors = 0;
  int checks_done = 0;
  localparam logic [31:0] ID = {4'h3, 16'h1234, 11'h055, 1'b1}; // arbitrary id
  scan_ctl ctl (.test_clock(tclk), .test_mode_select(tms), .test_data_in(tdi),
    .test_reset_n(trst_n), .tdo_line(tdo_line));
  boundary_scan_tap #(.ID_VERSION(ID[31:28]), .ID_PART(ID[27:12]), .ID_MAKER(ID[11:1]))
    DUT (.clock(clock), .rst(rst), .test_reset_n(trst_n), .test_clock(tclk),
    .test_mode_select(tms), .test_data_in(tdi), .test_data_out(tdo),
    .test_data_out_oe(tdo_oe), .pin_in(pin_in), .core_in(core_in),
    .core_out(core_out), .core_oe(core_oe), .pin_out(pin_out), .pin_oe(pin_oe));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // load an instruction, checking the fixed capture pattern
  task automatic ir(input logic [2:0] op);
    ctl.scan(1'b1, {29'h0, op}, 3, d, -1);
    `CHK("ir capture", 32'h1, d)
  endtask : ir
  // identify code after power-up, pins left to system logic
  task automatic t_idcode();
    `CHK("oe idle", 1'b0, tdo_oe)
    `CHK("pins", core_out, pin_out)
    `CHK("core in", pin_in, core_in)
    ctl.step(1'b0, 1'b0, d[0]);
    ctl.scan(1'b0, 32'h0, 32, d, -1);
    `CHK("id", ID, d)
  endtask : t_idcode
  // sample pins, preload boundary, then drive it out
  task automatic t_sample_extest();
    ir(3'h2);
    ctl.scan(1'b0, 32'hC35A, 16, d, -1);
    `CHK("sample", {16'h0, core_out, pin_in}, d)
    ir(3'h0);
    `CHK("extest out", 8'hC3, pin_out)
    `CHK("extest oe", 8'hFF, pin_oe)
  endtask : t_sample_extest
  // clamp, highz and bypass all route through the one-bit stage
  task automatic t_bypass_modes();
    logic [2:0] ops [3] = '{3'h3, 3'h4, 3'h7};
    foreach (ops[i]) begin
      ir(ops[i]);
      ctl.scan(1'b0, 32'hB4, 8, d, -1);
      `CHK("bypass", 32'h68, d)
      `CHK("oe", ops[i] == 3'h4 ? 8'h00 : (ops[i] == 3'h3 ? 8'hFF : core_oe), pin_oe)
      if (ops[i] != 3'h4) begin
        `CHK("out", ops[i] == 3'h3 ? 8'hC3 : core_out, pin_out)
      end
    end
  endtask : t_bypass_modes
  // both ways back to reset restore the identify instruction
  task automatic t_resets();
    for (int h = 0; h < 2; h++) begin
      ir(3'h7);
      ctl.to_reset(h[0]);
      ctl.scan(1'b0, 32'h0, 32, d, -1);
      `CHK("id after reset", ID, d)
    end
  endtask : t_resets
  // paused scans keep their bits; exit2 both resumes shifting and updates
  task automatic t_pause();
    ctl.scan(1'b1, 32'h2, 3, d, 1);
    `CHK("paused ir capture", 32'h1, d)
    ctl.scan(1'b0, 32'hA5C3, 16, d, 7);
    `CHK("paused sample", {16'h0, core_out, pin_in}, d)
    ctl.scan(1'b0, 32'h7E00, 16, d, 15);
    `CHK("sample again", {16'h0, core_out, pin_in}, d)
    ir(3'h0);
    `CHK("update from exit2", 8'h7E, pin_out)
  endtask : t_pause
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop
  // watchdog: the tests take about 15 us
  initial begin
    #200000;
    errors++;
    $display("mismatch watchdog expected done seen hang");
    report_and_stop();
  end
  initial begin
    rst = 1'b1;
    pin_in = 8'h96;
    core_out = 8'h5A;
    core_oe = 8'h0F;
    repeat (3) @(negedge clock);
    rst = 1'b0;
    repeat (3) @(negedge clock);
    t_idcode();
    t_sample_extest();
    t_bypass_modes();
    t_resets();
    t_pause();
    report_and_stop();
  end
endmodule : tb
